// ===== logic/sfpes_flash_seq.sv
// Overview of operation
// - Quad program refused unless quad enable set
// - 32h, 24-bit address, data, four bits per clock
// - Quad program needs write enable latch set
// - 20h erases addressed 4 KB sector
// - 52h erases addressed 32 KB block
// - D8h erases addressed 64 KB block
// - C7h or 60h erases whole array
// - Erases need write enable latch set
// - Chip select must rise on byte boundary
// - Self-timed cycle holds busy, then clears
// - Finished cycle clears write enable latch
// - Protected targets refused; chip erase if any
// - Suspend only when busy, not yet suspended
// - Suspend ignored during chip erase
// - Erase suspend blocks status write and erases
// - Program suspend blocks status write and programs
// - Suspend flag at once, busy drops within latency
// - Reset releases suspend and clears its flag
// - Data past page end wraps within page
// - Resume clears suspend flag, sets busy quickly
`timescale 1ns/1ps
`default_nettype none
module sfpes_flash_seq #(
	parameter int unsigned PROGRAM_CYCLES = sfpes_pkg::PROGRAM_TIME_US * sfpes_pkg::CLK_MHZ,
	parameter int unsigned SECTOR_CYCLES  = sfpes_pkg::SECTOR_ERASE_TIME_US * sfpes_pkg::CLK_MHZ,
	parameter int unsigned BLOCK32_CYCLES =
		sfpes_pkg::SMALL_BLOCK_ERASE_TIME_US * sfpes_pkg::CLK_MHZ,
	parameter int unsigned BLOCK64_CYCLES =
		sfpes_pkg::BLOCK64_ERASE_TIME_US * sfpes_pkg::CLK_MHZ,
	parameter int unsigned CHIP_CYCLES    = sfpes_pkg::CHIP_ERASE_TIME_US * sfpes_pkg::CLK_MHZ,
	parameter int unsigned SUSPEND_CYCLES = sfpes_pkg::SUSPEND_LATENCY_US * sfpes_pkg::CLK_MHZ
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	input  wire logic                  cs_b_in,
	input  wire logic                  sclk_in,
	input  wire logic [3:0]            io_in,
	input  wire logic                  quad_io_enable_in,
	input  wire logic                  block_protect_bit2_in,
	input  wire logic                  block_protect_bit1_in,
	input  wire logic                  block_protect_bit0_in,
	input  wire logic                  top_bottom_select_in,
	input  wire logic                  sector_granularity_select_in,
	input  wire logic                  protect_complement_in,
	input  wire logic                  lock_all_in,
	output logic                       busy_out,
	output logic                       suspend_flag_out,
	output logic                       write_enable_latch_out,
	output logic                       op_start_out,
	output logic                       op_done_out,
	output logic                       op_run_out,
	output sfpes_pkg::sfpes_op_t       op_kind_out,
	output logic [23:0]                op_addr_out,
	output logic                       pgm_wr_out,
	output logic [7:0]                 pgm_offset_out,
	output logic [7:0]                 pgm_data_out
);
	import sfpes_pkg::*;

	sfpes_link_if lk ();

	// Pin synchroniser and edge finder
	sfpes_link_rx u_rx (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.cs_b_in  (cs_b_in),
		.sclk_in  (sclk_in),
		.io_in    (io_in),
		.lk       (lk.rx)
	);

	// Frame decoder state
	logic [7:0]   sh;
	logic [2:0]   bit_cnt;
	logic [2:0]   byte_cnt;
	logic         quad;
	logic         drop;
	logic         got_data;
	logic [7:0]   opcode;
	logic [23:0]  addr_in;
	logic [7:0]   page_off;
	logic [7:0]   next_sh;
	logic [2:0]   next_bit_cnt;
	logic [2:0]   next_byte_cnt;
	logic         next_quad;
	logic         next_drop;
	logic         next_got_data;
	logic [7:0]   next_opcode;
	logic [23:0]  next_addr_in;
	logic [7:0]   next_page_off;
	logic         next_pgm_wr;
	logic [7:0]   next_pgm_offset;
	logic [7:0]   next_pgm_data;

	// Sequencer state
	sfpes_state_t state;
	sfpes_op_t    op_kind;
	sfpes_op_t    saved_kind;
	logic [31:0]  timer;
	logic [31:0]  saved_timer;
	logic [31:0]  halt_cnt;
	logic         suspend_flag;
	logic         write_enable_latch;
	sfpes_state_t next_state;
	sfpes_op_t    next_op_kind;
	sfpes_op_t    next_saved_kind;
	logic [31:0]  next_timer;
	logic [31:0]  next_saved_timer;
	logic [31:0]  next_halt_cnt;
	logic         next_sus;
	logic         next_wel;
	logic         next_start;
	logic         next_done;
	logic [23:0]  next_op_addr;

	logic [2:0]   bp;
	logic         frame_ok;
	logic         prog_banned;
	logic         erase_banned;
	sfpes_op_t    launch;
	logic [23:0]  base;

	assign bp = {block_protect_bit2_in, block_protect_bit1_in, block_protect_bit0_in};

	// True when an address falls in the protected range
	function automatic logic prot_hit(input logic [23:0] a);
		logic [23:0] len;
		logic        hit;
		len = 24'h0;
		hit = 1'b0;
		if (bp != 3'h0) begin
			if (sector_granularity_select_in) begin
				len = PROT_SECTOR_UNIT << ((bp > 3'h4) ? 3'h3 : (bp - 3'h1));
			end else begin
				len = PROT_BLOCK_UNIT << (bp - 3'h1);
			end
			hit = top_bottom_select_in ? (a < len) : (a >= (24'h0 - len));
		end
		return hit ^ protect_complement_in;
	endfunction

	// Low address bits that a region ignores
	function automatic logic [23:0] region_mask(input sfpes_op_t k);
		case (k)
			SFPES_OP_PROGRAM: region_mask = PAGE_MASK;
			SFPES_OP_SECTOR:  region_mask = SECTOR_MASK;
			SFPES_OP_BLOCK32: region_mask = BLOCK32_MASK;
			SFPES_OP_BLOCK64: region_mask = BLOCK64_MASK;
			default:          region_mask = CHIP_MASK;
		endcase
	endfunction

	// Self-timed length of each cycle
	function automatic logic [31:0] cycles_of(input sfpes_op_t k);
		case (k)
			SFPES_OP_PROGRAM: cycles_of = PROGRAM_CYCLES;
			SFPES_OP_SECTOR:  cycles_of = SECTOR_CYCLES;
			SFPES_OP_BLOCK32: cycles_of = BLOCK32_CYCLES;
			SFPES_OP_BLOCK64: cycles_of = BLOCK64_CYCLES;
			default:          cycles_of = CHIP_CYCLES;
		endcase
	endfunction

	// Commands barred while a cycle is suspended
	assign prog_banned  = suspend_flag && (saved_kind == SFPES_OP_PROGRAM);
	assign erase_banned = suspend_flag && (saved_kind != SFPES_OP_PROGRAM);
	// Chip select must rise just after a whole byte
	assign frame_ok     = !drop && (bit_cnt == 3'h0);

	// Frame decoder: shifts opcode, address and data bytes
	always_comb begin
		logic [7:0] shifted;
		shifted         = quad ? {sh[3:0], lk.io} : {sh[6:0], lk.io[0]};
		next_sh         = sh;
		next_bit_cnt    = bit_cnt;
		next_byte_cnt   = byte_cnt;
		next_quad       = quad;
		next_drop       = drop;
		next_got_data   = got_data;
		next_opcode     = opcode;
		next_addr_in    = addr_in;
		next_page_off   = page_off;
		next_pgm_wr     = 1'b0;
		next_pgm_offset = pgm_offset_out;
		next_pgm_data   = pgm_data_out;
		if (lk.cs_fall) begin
			next_bit_cnt  = 3'h0;
			next_byte_cnt = 3'h0;
			next_quad     = 1'b0;
			next_drop     = 1'b0;
			next_got_data = 1'b0;
		end else if (lk.sclk_rise && lk.cs_low && !drop) begin
			next_sh      = shifted;
			next_bit_cnt = bit_cnt + (quad ? 3'h4 : 3'h1);
			if (next_bit_cnt == 3'h0) begin
				if (byte_cnt == 3'h0) begin
					next_opcode = shifted;
					if (shifted == OP_QUAD_PROGRAM) begin
						if (!quad_io_enable_in) begin
							next_drop = 1'b1;
						end else if (!write_enable_latch) begin
							next_drop = 1'b1;
						end else if (busy_out || prog_banned) begin
							next_drop = 1'b1;
						end else begin
							next_quad = 1'b1;
						end
					end
				end else if (byte_cnt < DATA_BYTE_INDEX) begin
					next_addr_in  = {addr_in[15:0], shifted};
					next_page_off = shifted;
				end else begin
					next_got_data = 1'b1;
					if (opcode == OP_QUAD_PROGRAM) begin
						next_pgm_wr     = 1'b1;
						next_pgm_offset = page_off;
						next_pgm_data   = shifted;
						next_page_off   = page_off + 8'h1;
					end
				end
				if (byte_cnt < DATA_BYTE_INDEX) begin
					next_byte_cnt = byte_cnt + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sh             <= 8'h0;
			bit_cnt        <= 3'h0;
			byte_cnt       <= 3'h0;
			quad           <= 1'b0;
			drop           <= 1'b0;
			got_data       <= 1'b0;
			opcode         <= 8'h0;
			addr_in        <= 24'h0;
			page_off       <= 8'h0;
			pgm_wr_out     <= 1'b0;
			pgm_offset_out <= 8'h0;
			pgm_data_out   <= 8'h0;
		end else begin
			sh             <= next_sh;
			bit_cnt        <= next_bit_cnt;
			byte_cnt       <= next_byte_cnt;
			quad           <= next_quad;
			drop           <= next_drop;
			got_data       <= next_got_data;
			opcode         <= next_opcode;
			addr_in        <= next_addr_in;
			page_off       <= next_page_off;
			pgm_wr_out     <= next_pgm_wr;
			pgm_offset_out <= next_pgm_offset;
			pgm_data_out   <= next_pgm_data;
		end
	end

	// Sequencer: runs, halts, resumes and ends the self-timed cycles
	always_comb begin
		next_state       = state;
		next_op_kind     = op_kind;
		next_saved_kind  = saved_kind;
		next_timer       = timer;
		next_saved_timer = saved_timer;
		next_halt_cnt    = halt_cnt;
		next_sus         = suspend_flag;
		next_wel         = write_enable_latch;
		next_start       = 1'b0;
		next_done        = 1'b0;
		next_op_addr     = op_addr_out;
		launch           = SFPES_OP_NONE;
		base             = 24'h0;
		case (state)
			ST_RUN: begin
				if (timer <= 32'h1) begin
					next_state   = ST_IDLE;
					next_op_kind = SFPES_OP_NONE;
					next_wel     = 1'b0;
					next_done    = 1'b1;
				end else begin
					next_timer = timer - 32'h1;
				end
			end
			ST_HALT: begin
				if (halt_cnt <= 32'h1) begin
					next_saved_timer = timer;
					next_saved_kind  = op_kind;
					next_op_kind     = SFPES_OP_NONE;
					next_state       = ST_IDLE;
				end else begin
					next_halt_cnt = halt_cnt - 32'h1;
				end
			end
			default: begin
			end
		endcase
		if (lk.cs_rise && frame_ok) begin
			case (opcode)
				OP_WRITE_ENABLE: begin
					if (byte_cnt == OPCODE_ONLY_BYTES && !busy_out) begin
						next_wel = 1'b1;
					end
				end
				OP_WRITE_DISABLE: begin
					if (byte_cnt == OPCODE_ONLY_BYTES && !busy_out) begin
						next_wel = 1'b0;
					end
				end
				OP_QUAD_PROGRAM: begin
					if (got_data && quad_io_enable_in && write_enable_latch && !prog_banned) begin
						launch = SFPES_OP_PROGRAM;
					end
				end
				OP_SECTOR_ERASE: begin
					if (byte_cnt == DATA_BYTE_INDEX && !got_data) begin
						launch = SFPES_OP_SECTOR;
					end
				end
				OP_BLOCK32_ERASE: begin
					if (byte_cnt == DATA_BYTE_INDEX && !got_data) begin
						launch = SFPES_OP_BLOCK32;
					end
				end
				OP_BLOCK64_ERASE: begin
					if (byte_cnt == DATA_BYTE_INDEX && !got_data) begin
						launch = SFPES_OP_BLOCK64;
					end
				end
				OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
					if (byte_cnt == OPCODE_ONLY_BYTES) begin
						launch = SFPES_OP_CHIP;
					end
				end
				OP_SUSPEND: begin
					if (byte_cnt == OPCODE_ONLY_BYTES && state == ST_RUN && !suspend_flag
						&& timer > 32'h1 && op_kind != SFPES_OP_CHIP) begin
						next_sus      = 1'b1;
						next_state    = ST_HALT;
						next_halt_cnt = SUSPEND_CYCLES;
					end
				end
				OP_RESUME: begin
					if (byte_cnt == OPCODE_ONLY_BYTES && suspend_flag && !busy_out) begin
						next_sus        = 1'b0;
						next_state      = ST_RUN;
						next_op_kind    = saved_kind;
						next_timer      = saved_timer;
						next_saved_kind = SFPES_OP_NONE;
					end
				end
				default: begin
				end
			endcase
		end
		// Erases gated by the latch, busy, suspend bans and protection
		if (launch != SFPES_OP_NONE && launch != SFPES_OP_PROGRAM) begin
			if (!write_enable_latch || erase_banned) begin
				launch = SFPES_OP_NONE;
			end
		end
		base = addr_in & ~region_mask(launch);
		if (busy_out || lock_all_in || prot_hit(base)
			|| prot_hit(base | region_mask(launch))) begin
			launch = SFPES_OP_NONE;
		end
		if (launch != SFPES_OP_NONE) begin
			next_state   = ST_RUN;
			next_op_kind = launch;
			next_timer   = cycles_of(launch);
			next_op_addr = base;
			next_start   = 1'b1;
		end
	end

	// Reset also releases any suspended cycle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state                  <= ST_IDLE;
			op_kind                <= SFPES_OP_NONE;
			saved_kind             <= SFPES_OP_NONE;
			timer                  <= 32'h0;
			saved_timer            <= 32'h0;
			halt_cnt               <= 32'h0;
			suspend_flag                    <= SUSPEND_RESET;
			write_enable_latch                    <= WEL_RESET;
			busy_out               <= 1'b0;
			suspend_flag_out       <= SUSPEND_RESET;
			write_enable_latch_out <= WEL_RESET;
			op_start_out           <= 1'b0;
			op_done_out            <= 1'b0;
			op_run_out             <= 1'b0;
			op_kind_out            <= SFPES_OP_NONE;
			op_addr_out            <= 24'h0;
		end else begin
			state                  <= next_state;
			op_kind                <= next_op_kind;
			saved_kind             <= next_saved_kind;
			timer                  <= next_timer;
			saved_timer            <= next_saved_timer;
			halt_cnt               <= next_halt_cnt;
			suspend_flag                    <= next_sus;
			write_enable_latch                    <= next_wel;
			busy_out               <= (next_state != ST_IDLE);
			suspend_flag_out       <= next_sus;
			write_enable_latch_out <= next_wel;
			op_start_out           <= next_start;
			op_done_out            <= next_done;
			op_run_out             <= (next_state == ST_RUN);
			op_kind_out            <= next_op_kind;
			op_addr_out            <= next_op_addr;
		end
	end
endmodule
`default_nettype wire

// ===== logic/sfpes_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Cleaned link events passed from the pin front end to the sequencer
interface sfpes_link_if;
	logic       sclk_rise;
	logic       cs_low;
	logic       cs_fall;
	logic       cs_rise;
	logic [3:0] io;
	modport rx (output sclk_rise, output cs_low, output cs_fall, output cs_rise, output io);
	modport core (input sclk_rise, input cs_low, input cs_fall, input cs_rise, input io);
endinterface
`default_nettype wire

// ===== logic/sfpes_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_link_rx (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       cs_b_in,
	input  wire logic       sclk_in,
	input  wire logic [3:0] io_in,
	sfpes_link_if.rx        lk
);
	import sfpes_pkg::*;

	logic [5:0] stage1;
	logic [5:0] stage2;
	logic [5:0] stage3;
	logic [5:0] filt;
	logic [5:0] prev;
	logic [5:0] next_filt;

	// A bit changes only once the second and third stages agree
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			next_filt[i] = (stage2[i] == stage3[i]) ? stage3[i] : filt[i];
		end
	end

	// Three-stage synchroniser, filter and edge history
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage1 <= LINK_RESET;
			stage2 <= LINK_RESET;
			stage3 <= LINK_RESET;
			filt   <= LINK_RESET;
			prev   <= LINK_RESET;
		end else begin
			stage1 <= {cs_b_in, sclk_in, io_in};
			stage2 <= stage1;
			stage3 <= stage2;
			filt   <= next_filt;
			prev   <= filt;
		end
	end

	// Edge events and cs/io levels from the filtered bits
	assign lk.sclk_rise = filt[4] & ~prev[4];
	assign lk.cs_low    = ~filt[5];
	assign lk.cs_fall   = ~filt[5] & prev[5];
	assign lk.cs_rise   = filt[5] & ~prev[5];
	assign lk.io        = filt[3:0];
endmodule
`default_nettype wire

// ===== logic/sfpes_pkg.sv
`default_nettype none
package sfpes_pkg;
	// Opcodes
	localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
	localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
	localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
	localparam logic [7:0] OP_QUAD_PROGRAM   = 8'h32;
	localparam logic [7:0] OP_PROGRAM_42     = 8'h42;
	localparam logic [7:0] OP_ERASE_44       = 8'h44;
	localparam logic [7:0] OP_BLOCK32_ERASE  = 8'h52;
	localparam logic [7:0] OP_CHIP_ERASE_B   = 8'h60;
	localparam logic [7:0] OP_SUSPEND        = 8'h75;
	localparam logic [7:0] OP_RESUME         = 8'h7a;
	localparam logic [7:0] OP_CHIP_ERASE_A   = 8'hc7;
	localparam logic [7:0] OP_BLOCK64_ERASE  = 8'hd8;
	// Frame layout: opcode byte, three address bytes, then data
	localparam logic [2:0] OPCODE_ONLY_BYTES = 3'h1;
	localparam logic [2:0] DATA_BYTE_INDEX   = 3'h4;
	// Region masks of the low address bits
	localparam logic [23:0] PAGE_MASK        = 24'h0000ff;
	localparam logic [23:0] SECTOR_MASK      = 24'h000fff;
	localparam logic [23:0] BLOCK32_MASK     = 24'h007fff;
	localparam logic [23:0] BLOCK64_MASK     = 24'h00ffff;
	localparam logic [23:0] CHIP_MASK        = 24'hffffff;
	// Protection granule sizes
	localparam logic [23:0] PROT_SECTOR_UNIT = 24'h001000;
	localparam logic [23:0] PROT_BLOCK_UNIT  = 24'h010000;
	// Self-timed durations
	localparam int CLK_MHZ                   = 250;
	localparam int PROGRAM_TIME_US           = 400;
	localparam int SECTOR_ERASE_TIME_US      = 50000;
	localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
	localparam int BLOCK64_ERASE_TIME_US     = 150000;
	localparam int CHIP_ERASE_TIME_US        = 1000000;
	localparam int SUSPEND_LATENCY_US        = 20;
	// Reset values; link bits are {cs, sclk, io[3:0]}
	localparam logic [5:0] LINK_RESET        = 6'h20;
	localparam logic       WEL_RESET         = 1'b0;
	localparam logic       SUSPEND_RESET     = 1'b0;

	typedef enum logic [2:0] {
		SFPES_OP_NONE,
		SFPES_OP_PROGRAM,
		SFPES_OP_SECTOR,
		SFPES_OP_BLOCK32,
		SFPES_OP_BLOCK64,
		SFPES_OP_CHIP
	} sfpes_op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HALT
	} sfpes_state_t;
endpackage
`default_nettype wire

// ===== verif/sfpes_flash_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_flash_seq_tb;
	import sfpes_pkg::*;
	localparam int SUSPEND_FLAG = 20;
	logic clk_in = 1'b0, rst_b_in = 1'b0, quad = 1'b0, bp0 = 1'b0, tbs = 1'b0, lock = 1'b0;
	logic bp1 = 1'b0, bp2 = 1'b0, sec = 1'b0, cmp = 1'b0;
	logic cs_b, sclk, busy, suspend_flag, write_enable_latch, start, done, run, wr;
	logic [3:0] io;
	logic [7:0] offs, dat;
	logic [23:0] addr;
	sfpes_op_t kind;
	logic [15:0] wr_q[$];
	int err_total = 0, tests_run = 0, cycles = 0;
	always #2 clk_in = ~clk_in;
	sfpes_host_model sfpes_host_model_i (.clk_in(clk_in), .cs_b_out(cs_b), .sclk_out(sclk),
		.io_out(io));
	sfpes_flash_seq #(.PROGRAM_CYCLES(600), .SECTOR_CYCLES(600), .BLOCK32_CYCLES(300),
		.BLOCK64_CYCLES(350), .CHIP_CYCLES(700), .SUSPEND_CYCLES(SUSPEND_FLAG)) sfpes_flash_seq_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk), .io_in(io),
		.quad_io_enable_in(quad), .block_protect_bit2_in(bp2), .block_protect_bit1_in(bp1),
		.block_protect_bit0_in(bp0), .top_bottom_select_in(tbs),
		.sector_granularity_select_in(sec), .protect_complement_in(cmp), .lock_all_in(lock),
		.busy_out(busy), .suspend_flag_out(suspend_flag), .write_enable_latch_out(write_enable_latch),
		.op_start_out(start), .op_done_out(done), .op_run_out(run), .op_kind_out(kind),
		.op_addr_out(addr), .pgm_wr_out(wr), .pgm_offset_out(offs), .pgm_data_out(dat));
	// Collect received program bytes
	always @(posedge clk_in) begin
		cycles++;
		if (wr === 1'b1) wr_q.push_back({offs, dat});
		if (cycles == 80000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] op, input logic [23:0] a, input int n, input int x);
		sfpes_host_model_i.frame('{op, a[23:16], a[15:8], a[7:0], 8'ha5, 8'h3c, 8'h96, 8'h00},
			n, op == OP_QUAD_PROGRAM, x);
	endtask
	task automatic wait_done();
		int i;
		for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge clk_in);
		chk({23'h0, done}, 24'h1, "cycle end");
		repeat (4) @(posedge clk_in);
	endtask
	task automatic do_rst();
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (6) @(posedge clk_in);
	endtask
	logic [7:0] ops [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_CHIP_ERASE_A,
		OP_CHIP_ERASE_B};
	sfpes_op_t kinds [5] = '{SFPES_OP_SECTOR, SFPES_OP_BLOCK32, SFPES_OP_BLOCK64, SFPES_OP_CHIP,
		SFPES_OP_CHIP};
	logic [23:0] masks [5] = '{SECTOR_MASK, BLOCK32_MASK, BLOCK64_MASK, CHIP_MASK, CHIP_MASK};
	initial begin
		int i;
		logic [23:0] ea;
		do_rst();
		chk({busy, suspend_flag, write_enable_latch}, 24'h0, "reset flags");
		quad <= 1'b1;
		send(OP_QUAD_PROGRAM, 24'h0012fe, 7, 0);
		send(OP_SECTOR_ERASE, 24'h001000, 4, 0);
		chk({busy, write_enable_latch}, 24'h0, "no latch refusal");
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		quad <= 1'b0;
		send(OP_QUAD_PROGRAM, 24'h0012fe, 7, 0);
		chk({busy, write_enable_latch, 22'(wr_q.size())}, 24'h400000, "quad off refusal");
		quad <= 1'b1;
		send(OP_QUAD_PROGRAM, 24'h0012fe, 7, 0);
		ea = {1'b1, SFPES_OP_PROGRAM, 20'h01200};
		chk({busy, kind, addr[19:0]}, ea, "program launch");
		chk({wr_q[0], wr_q[1][15:8]}, 24'hfea5ff, "bytes 0 1");
		chk({wr_q[1][7:0], wr_q[2]}, 24'h3c0096, "page wrap");
		wait_done();
		chk({busy, write_enable_latch}, 24'h0, "after program");
		$display("test program done");
		for (i = 0; i < 5; i++) begin
			send(OP_WRITE_ENABLE, 24'h0, 1, 0);
			send(ops[i], 24'h123456, i < 3 ? 4 : 1, 0);
			ea = {kinds[i], 21'(24'h123456 & ~masks[i])};
			chk({kind, addr[20:0]}, ea, "launch");
			if (i == 0) send(OP_BLOCK64_ERASE, 24'h0, 4, 0);
			chk({busy, kind}, {1'b1, kinds[i]}, "busy ignore");
			wait_done();
			chk({busy, write_enable_latch}, 24'h0, "after erase");
		end
		$display("test erase done");
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_SECTOR_ERASE, 24'h002000, 4, 3);
		chk({busy, write_enable_latch}, 24'h1, "stray clocks");
		bp0 <= 1'b1;
		send(OP_SECTOR_ERASE, 24'hfff000, 4, 0);
		send(OP_CHIP_ERASE_A, 24'h0, 1, 0);
		tbs <= 1'b1;
		send(OP_SECTOR_ERASE, 24'h000000, 4, 0);
		chk({busy, write_enable_latch}, 24'h1, "protected refusal");
		send(OP_SECTOR_ERASE, 24'hfff000, 4, 0);
		chk({busy, kind}, {1'b1, SFPES_OP_SECTOR}, "unprotected accepted");
		wait_done();
		// Sector granules: bottom 32 KB protected, then complement frees it
		bp0 <= 1'b0;
		{bp2, bp1, sec} <= 3'h7;
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_SECTOR_ERASE, 24'h001000, 4, 0);
		chk({busy, write_enable_latch}, 24'h1, "granule refusal");
		cmp <= 1'b1;
		send(OP_SECTOR_ERASE, 24'h001000, 4, 0);
		chk({busy, kind}, {1'b1, SFPES_OP_SECTOR}, "complement accepted");
		wait_done();
		{bp2, bp1, sec, cmp} <= 4'h0;
		lock <= 1'b1;
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_SECTOR_ERASE, 24'h000000, 4, 0);
		chk({busy, write_enable_latch}, 24'h1, "lock refusal");
		lock <= 1'b0;
		$display("test protect done");
		send(OP_SUSPEND, 24'h0, 1, 0);
		chk({suspend_flag}, 24'h0, "idle suspend");
		send(OP_SECTOR_ERASE, 24'h003000, 4, 0);
		send(OP_SUSPEND, 24'h0, 1, 0);
		chk({suspend_flag, run}, 24'h2, "suspend taken");
		repeat (SUSPEND_FLAG + 10) @(posedge clk_in);
		chk({busy, kind}, {1'b0, SFPES_OP_NONE}, "halted");
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_SECTOR_ERASE, 24'h004000, 4, 0);
		send(OP_SUSPEND, 24'h0, 1, 0);
		chk({suspend_flag, busy}, 24'h2, "erase in suspend");
		send(OP_RESUME, 24'h0, 1, 0);
		chk({suspend_flag, busy, run}, 24'h3, "resumed");
		repeat (SUSPEND_FLAG) @(posedge clk_in);
		wait_done();
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_CHIP_ERASE_B, 24'h0, 1, 0);
		send(OP_SUSPEND, 24'h0, 1, 0);
		chk({suspend_flag, busy}, 24'h1, "chip erase suspend");
		wait_done();
		$display("test suspend done");
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_QUAD_PROGRAM, 24'h000400, 5, 0);
		send(OP_SUSPEND, 24'h0, 1, 0);
		repeat (SUSPEND_FLAG + 10) @(posedge clk_in);
		wr_q.delete();
		send(OP_WRITE_ENABLE, 24'h0, 1, 0);
		send(OP_QUAD_PROGRAM, 24'h000800, 5, 0);
		chk({suspend_flag, busy, 22'(wr_q.size())}, 24'h800000, "program in suspend");
		do_rst();
		chk({busy, suspend_flag, write_enable_latch}, 24'h0, "reset in suspend");
		$display("test program suspend done");
		give_verdict();
	end
endmodule
`default_nettype wire

// ===== verif/sfpes_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_host_model (
	input  wire logic       clk_in,
	output logic            cs_b_out,
	output logic            sclk_out,
	output logic [3:0]      io_out
);
	// Idle link: deselected, clock parked low
	initial begin
		cs_b_out = 1'b1;
		sclk_out = 1'b0;
		io_out = 4'h5;
	end
	// One link clock of 64 ns, data set up while the clock is low
	task automatic tick(input logic [3:0] v);
		@(posedge clk_in);
		sclk_out <= 1'b0;
		io_out <= v;
		repeat (8) @(posedge clk_in);
		sclk_out <= 1'b1;
		repeat (7) @(posedge clk_in);
	endtask
	// Whole frame; extra adds stray clocks after the last byte
	task automatic frame(input logic [7:0] b [8], input int n, input bit quad, input int extra);
		int i;
		int k;
		@(posedge clk_in);
		cs_b_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (i = 0; i < n; i++) begin
			if (quad && i > 0) begin
				tick(b[i][7:4]);
				tick(b[i][3:0]);
			end else begin
				for (k = 7; k >= 0; k--) tick({~{3{b[i][k]}}, b[i][k]});
			end
		end
		for (k = 0; k < extra; k++) tick(4'h0);
		@(posedge clk_in);
		sclk_out <= 1'b0;
		repeat (8) @(posedge clk_in);
		cs_b_out <= 1'b1;
		io_out <= ~io_out; // Released lines show the inverse of the last value
		repeat (10) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ===== verif/sfpes_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_seq_monitor
	import sfpes_pkg::*;
#(
	parameter int SUSPEND_CYCLES = 20
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	input  wire logic                  quad_io_enable_in,
	input  wire logic                  lock_all_in,
	input  wire logic                  busy_out,
	input  wire logic                  suspend_flag_out,
	input  wire logic                  write_enable_latch_out,
	input  wire logic                  op_start_out,
	input  wire logic                  op_done_out,
	input  wire logic                  op_run_out,
	input  wire sfpes_pkg::sfpes_op_t  op_kind_out,
	input  wire logic [23:0]           op_addr_out
);
	localparam int SUS_MAX = SUSPEND_CYCLES + 2;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// Multi-step behaviours
	sequence s_sus_taken;
		$rose(suspend_flag_out) ##0 !op_run_out;
	endsequence
	sequence s_done_idle;
		##[0:1] (!busy_out && !write_enable_latch_out);
	endsequence
	property p_rst_idle;
		$rose(rst_b_in) |-> !busy_out && !suspend_flag_out && !write_enable_latch_out;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("flags set after reset");
	property p_launch;
		op_start_out |-> busy_out && op_run_out && !$past(busy_out);
	endproperty
	a_launch: assert property (p_launch) else $error("bad launch");
	property p_wel;
		op_start_out |-> write_enable_latch_out && !lock_all_in;
	endproperty
	a_wel: assert property (p_wel) else $error("launch without latch");
	property p_quad;
		op_start_out && op_kind_out == SFPES_OP_PROGRAM |-> quad_io_enable_in;
	endproperty
	a_quad: assert property (p_quad) else $error("program without quad");
	property p_done;
		op_done_out |-> s_done_idle;
	endproperty
	a_done: assert property (p_done) else $error("done but flags set");
	property p_sus_ok;
		$rose(suspend_flag_out) |-> $past(busy_out) && $past(op_kind_out) != SFPES_OP_CHIP
			&& $past(op_kind_out) != SFPES_OP_NONE;
	endproperty
	a_sus_ok: assert property (p_sus_ok) else $error("suspend not allowed");
	property p_sus_halt;
		s_sus_taken |-> ##[1:SUS_MAX] !busy_out;
	endproperty
	a_sus_halt: assert property (p_sus_halt) else $error("halt too slow");
	property p_resume;
		$fell(suspend_flag_out) |-> ##[0:49] (busy_out && op_run_out);
	endproperty
	a_resume: assert property (p_resume) else $error("resume slow");
	property p_base;
		op_start_out && op_kind_out == SFPES_OP_SECTOR |-> (op_addr_out & SECTOR_MASK) == 24'h0;
	endproperty
	a_base: assert property (p_base) else $error("sector base low bits");
endmodule
bind sfpes_flash_seq sfpes_seq_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) sfpes_seq_monitor_i (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .quad_io_enable_in(quad_io_enable_in),
	.lock_all_in(lock_all_in), .busy_out(busy_out), .suspend_flag_out(suspend_flag_out),
	.write_enable_latch_out(write_enable_latch_out), .op_start_out(op_start_out),
	.op_done_out(op_done_out), .op_run_out(op_run_out), .op_kind_out(op_kind_out),
	.op_addr_out(op_addr_out)
);
`default_nettype wire
